// ### logic/cfl_pkg.sv
package cfl_pkg;
  // Clock rate and the master hold time, rounded up to whole cycles.
  localparam int unsigned CLK_PERIOD_NS      = 40;
  localparam int unsigned MASTER_HOLD_MIN_US = 30;
  localparam int unsigned MASTER_HOLD_CYCLES =
    (MASTER_HOLD_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CNT_W         = 10;
  localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(MASTER_HOLD_CYCLES - 1);
  // Memory clear and PROM access times in cycles.
  localparam logic [7:0] MEM_CLEAR_LAST   = 8'h3f;
  localparam logic [7:0] PROM_ACCESS_LAST = 8'h03;
  localparam logic [7:0] CNT_ZERO         = 8'h00;
  // Widths of the PROM address and the data byte.
  localparam int unsigned ADDR_LOW_W = 18;
  localparam int unsigned ADDR_EXT_W = 4;
  localparam int unsigned ADDR_W     = ADDR_LOW_W + ADDR_EXT_W;
  localparam int unsigned BYTE_W     = 8;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 22'h000000;
  localparam logic [ADDR_W-1:0] ADDR_ONE   = 22'h000001;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [6:0]        STATUS_PAD = 7'h7f;
  // Mode select codes.
  localparam logic [2:0] MODE_MASTER_SER = 3'h0;
  localparam logic [2:0] MODE_MASTER_PAR = 3'h6;
  localparam logic [2:0] MODE_PERIPH     = 3'h5;
  localparam logic [2:0] MODE_EXPRESS    = 3'h2;
  localparam logic [2:0] MODE_RESET      = 3'h7;
  // Host side pins of the peripheral port.
  typedef struct packed {
    logic              cs_low_n;
    logic              cs_high;
    logic              write_strobe_n;
    logic              read_strobe_n;
    logic [BYTE_W-1:0] data;
  } cfl_host_pins_s;
  localparam cfl_host_pins_s HOST_IDLE = 12'hbff;
  typedef enum logic [2:0] {
    ST_POWER, ST_CLEAR, ST_WAIT_INIT, ST_MASTER_WAIT, ST_CONFIG, ST_ERROR, ST_DONE
  } cfl_state_e;
  typedef enum logic [1:0] {F_WAIT, F_SAMPLE, F_EDGE, F_STEP} cfl_fetch_e;
endpackage

// ### logic/cfl_port.sv
module cfl_port
  import cfl_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic                  rstn_in,
  input  wire logic                  power_stable_in,
  input  wire logic                  cfg_error_in,
  input  wire logic                  io_active_in,
  input  wire logic                  wide_addr_in,
  input  wire logic [2:0]            mode_select_pins_in,
  input  wire logic                  init_n_in,
  output logic                       init_n_out,
  output logic                       init_n_oe_out,
  input  wire cfl_host_pins_s        host_pins_in,
  output logic [BYTE_W-1:0]          config_byte_bus_out,
  output logic                       config_byte_bus_oe_out,
  output logic                       host_ready_flag_out,
  output logic [ADDR_LOW_W-1:0]      prom_addr_low_out,
  output logic [ADDR_EXT_W-1:0]      prom_addr_ext_out,
  output logic                       addr_change_strobe_out,
  output logic [2:0]                 mode_out,
  output logic [BYTE_W-1:0]          cfg_byte_out,
  output logic                       cfg_byte_valid_out,
  input  wire logic                  cfg_byte_ready_in
);
  // Pin inputs pass two flops; only the second stage is read by logic.
  logic           init_m, init_s;
  logic [2:0]     mode_m, mode_s;
  cfl_host_pins_s host_m, host_s;
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      init_m <= 1'b1;
      init_s <= 1'b1;
      mode_m <= MODE_RESET;
      mode_s <= MODE_RESET;
      host_m <= HOST_IDLE;
      host_s <= HOST_IDLE;
    end else begin
      init_m <= init_n_in;
      init_s <= init_m;
      mode_m <= mode_select_pins_in;
      mode_s <= mode_m;
      host_m <= host_pins_in;
      host_s <= host_m;
    end
  end

  cfl_state_e            state, next_state;
  cfl_fetch_e            fetch, next_fetch;
  logic [HOLD_CNT_W-1:0] hold_cnt, next_hold_cnt;
  logic [7:0]            cnt, next_cnt;
  logic [2:0]            mode, next_mode;
  logic [ADDR_W-1:0]     addr, next_addr;
  logic [BYTE_W-1:0]     buf_data, next_buf_data, bus_data, next_bus_data;
  logic                  buf_full, next_buf_full, bus_oe, next_bus_oe;
  logic                  strobe, next_strobe, init_oe, next_init_oe;
  logic                  wr_prev, next_wr_prev;
  logic                  is_master, in_cfg, sel, wr_act, rd_act, wr_take;

  // Select decode; express mode gates on the high select alone.
  always_comb begin
    is_master = (mode == MODE_MASTER_SER) || (mode == MODE_MASTER_PAR);
    in_cfg    = (state == ST_CONFIG);
    if (mode == MODE_EXPRESS) begin
      sel = host_s.cs_high;
    end else begin
      sel = !host_s.cs_low_n && host_s.cs_high;
    end
    wr_act  = in_cfg && (mode == MODE_PERIPH || mode == MODE_EXPRESS) && sel &&
              !host_s.write_strobe_n;
    // A write taken on the strobe's leading level; a full buffer drops it.
    wr_take = wr_act && !wr_prev && !buf_full;
    // Write strobe overrides a simultaneous read.
    rd_act  = in_cfg && mode == MODE_PERIPH && sel && !host_s.read_strobe_n &&
              host_s.write_strobe_n;
  end

  // Next state of the sequencer, buffer, port and PROM fetch.
  always_comb begin
    next_state    = state;
    next_fetch    = fetch;
    next_hold_cnt = hold_cnt;
    next_cnt      = cnt;
    next_mode     = mode;
    next_addr     = addr;
    next_buf_data = buf_data;
    next_buf_full = buf_full;
    next_strobe   = 1'b0;
    next_wr_prev  = wr_act;
    next_init_oe  = 1'b0;
    next_bus_oe   = rd_act;
    next_bus_data = {!buf_full, STATUS_PAD};
    if (buf_full && cfg_byte_ready_in) begin
      next_buf_full = 1'b0;
    end
    case (state)
      ST_POWER: begin
        next_init_oe = 1'b1;
        if (power_stable_in) begin
          next_state = ST_CLEAR;
          next_cnt   = CNT_ZERO;
        end
      end
      ST_CLEAR: begin
        next_init_oe = 1'b1;
        next_cnt     = cnt + 8'h01;
        if (cnt == MEM_CLEAR_LAST) begin
          next_state   = ST_WAIT_INIT;
          next_init_oe = 1'b0;
        end
      end
      ST_WAIT_INIT: begin
        // An external low keeps the device here.
        if (init_s) begin
          next_mode     = mode_s;
          next_hold_cnt = '0;
          next_cnt      = CNT_ZERO;
          next_fetch    = F_WAIT;
          next_addr     = ADDR_RESET;
          if (mode_s == MODE_MASTER_SER || mode_s == MODE_MASTER_PAR) begin
            next_state = ST_MASTER_WAIT;
          end else begin
            next_state = ST_CONFIG;
          end
        end
      end
      ST_MASTER_WAIT: begin
        next_hold_cnt = hold_cnt + 1'b1;
        if (hold_cnt == HOLD_LAST) begin
          next_state = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (cfg_error_in) begin
          next_state   = ST_ERROR;
          next_init_oe = 1'b1;
          next_bus_oe  = 1'b0;
        end else if (io_active_in) begin
          next_state  = ST_DONE;
          next_bus_oe = 1'b0;
        end
        if (wr_take) begin
          next_buf_data = host_s.data;
          next_buf_full = 1'b1;
        end
        // PROM fetch: sample, raise the strobe, then step the address.
        if (mode == MODE_MASTER_PAR) begin
          case (fetch)
            F_WAIT: begin
              next_cnt = cnt + 8'h01;
              if (cnt == PROM_ACCESS_LAST) begin
                next_fetch = F_SAMPLE;
              end
            end
            F_SAMPLE: begin
              if (!buf_full) begin
                next_buf_data = host_s.data;
                next_buf_full = 1'b1;
                next_fetch    = F_EDGE;
              end
            end
            F_EDGE: begin
              next_strobe = 1'b1;
              next_fetch  = F_STEP;
            end
            F_STEP: begin
              next_addr  = addr + ADDR_ONE;
              next_cnt   = CNT_ZERO;
              next_fetch = F_WAIT;
            end
            default: next_fetch = F_WAIT;
          endcase
        end
      end
      ST_ERROR: begin
        // The error stays flagged until the device is reset.
        next_init_oe = 1'b1;
        next_bus_oe  = 1'b0;
      end
      ST_DONE: begin
        next_bus_oe = 1'b0;
      end
      default: next_state = ST_POWER;
    endcase
    if (state != ST_CONFIG) begin
      next_bus_oe = 1'b0;
    end
  end

  // Registers of the sequencer.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state    <= ST_POWER;
      fetch    <= F_WAIT;
      hold_cnt <= '0;
      cnt      <= CNT_ZERO;
      mode     <= MODE_RESET;
      addr     <= ADDR_RESET;
      buf_data <= BYTE_RESET;
      buf_full <= 1'b0;
      bus_data <= BYTE_RESET;
      bus_oe   <= 1'b0;
      strobe   <= 1'b0;
      init_oe  <= 1'b1;
      wr_prev  <= 1'b0;
    end else begin
      state    <= next_state;
      fetch    <= next_fetch;
      hold_cnt <= next_hold_cnt;
      cnt      <= next_cnt;
      mode     <= next_mode;
      addr     <= next_addr;
      buf_data <= next_buf_data;
      buf_full <= next_buf_full;
      bus_data <= next_bus_data;
      bus_oe   <= next_bus_oe;
      strobe   <= next_strobe;
      init_oe  <= next_init_oe;
      wr_prev  <= next_wr_prev;
    end
  end

  // Output drive; the hold/error line is open drain, so it only pulls low.
  assign init_n_out             = 1'b0;
  assign init_n_oe_out          = init_oe;
  assign config_byte_bus_out    = bus_data;
  assign config_byte_bus_oe_out = bus_oe;
  assign host_ready_flag_out    = !buf_full;
  assign prom_addr_low_out      = addr[ADDR_LOW_W-1:0];
  assign prom_addr_ext_out      = wide_addr_in ? addr[ADDR_W-1:ADDR_LOW_W] : '0;
  assign addr_change_strobe_out = strobe;
  assign mode_out               = mode;
  assign cfg_byte_out           = buf_data;
  assign cfg_byte_valid_out     = buf_full;

  // Checks on the sequencer and the ports.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  chk_hold_low_clear: assert property ((state == ST_CLEAR) |-> init_n_oe_out)
    else $error("hold line not driven during clear");
  chk_ext_hold_wait: assert property (state == ST_WAIT_INIT && !init_s |=>
    state == ST_WAIT_INIT) else $error("left hold while line low");
  chk_master_hold_len: assert property ($rose(state == ST_CONFIG) && is_master
    |-> $past(hold_cnt) == HOLD_LAST)
    else $error("master hold too short");
  chk_error_drive_low: assert property (state == ST_CONFIG && cfg_error_in |=>
    init_n_oe_out) else $error("error not flagged");
  chk_done_release: assert property (state == ST_DONE |-> !init_n_oe_out && !bus_oe)
    else $error("pins not released");
  chk_select_needed: assert property (mode == MODE_PERIPH &&
    (host_s.cs_low_n || !host_s.cs_high) |-> !wr_take ##1 !bus_oe)
    else $error("port answered unselected");
  chk_write_loads_buf: assert property (wr_take |=> buf_full &&
    buf_data == $past(host_s.data)) else $error("written byte not loaded");
  chk_read_status_bits: assert property (rd_act |=> bus_oe &&
    bus_data == {$past(!buf_full), STATUS_PAD}) else $error("bad status read");
  chk_write_wins_read: assert property (!host_s.write_strobe_n &&
    !host_s.read_strobe_n |=> !bus_oe) else $error("read driven during write");
  chk_express_gate: assert property (mode == MODE_EXPRESS && !host_s.cs_high |->
    !wr_take) else $error("express write while disabled");
  chk_strobe_first: assert property ($changed(addr) && state == ST_CONFIG |->
    $past(strobe)) else $error("address moved without strobe");
  chk_busy_held: assert property (buf_full && !cfg_byte_ready_in |=>
    !host_ready_flag_out) else $error("ready before drain");
  chk_mode_sampled: assert property (state == ST_WAIT_INIT && init_s |=>
    mode == $past(mode_s)) else $error("mode not sampled");
  cov_periph_write: cover property (wr_take ##[1:20] !buf_full);
  cov_status_read: cover property (rd_act ##1 bus_oe);
  cov_prom_step: cover property (strobe ##1 $changed(addr));
  cov_error_seen: cover property (state == ST_ERROR);
endmodule

// ### dv/cfl_prom_model.sv
module cfl_prom_model
  import cfl_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic [ADDR_LOW_W-1:0] addr_low_in,
  input  wire logic [ADDR_EXT_W-1:0] addr_ext_in,
  output logic      [BYTE_W-1:0]     data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // The byte follows the address a cycle late, so an early fetch sees stale data.
  always_ff @(posedge clk_sys_in) begin
    data_out <= addr_low_in[7:0] ^ {addr_ext_in, 4'h0} ^ 8'h5a;
  end
endmodule

// ### dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cfl_pkg::*;
  localparam int TIMEOUT_CYC = 5000;
  logic           clk_sys_in = 0, rstn_in = 0, power_stable = 0, cfg_error = 0, io_active = 0;
  logic           wide_addr = 0, ext_hold = 1, cs_low_n = 1, cs_high = 0, init_val;
  logic           write_strobe_n = 1, read_strobe_n = 1;
  logic           cons_rand = 0, cons_en = 1, ready_in = 1, strobe_seen = 0;
  logic [2:0]     mode_pins = 3'h5, mode;
  logic [7:0]     host_data = 8'h00, bus_out, cfg_byte, prom_data;
  logic           init_oe, bus_oe, ready_flag, strobe, valid;
  logic [17:0]    addr_low, last_addr = 18'h00000;
  logic [3:0]     addr_ext;
  logic [7:0]     exp_q[$];
  int             miscompares = 0, cmp_count = 0, cycles = 0, seed = 80, strobes = 0, i;
  cfl_host_pins_s pins;
  // PROM data reaches the byte bus only in master parallel mode.
  assign pins = {cs_low_n, cs_high, write_strobe_n, read_strobe_n,
                 (mode_pins == MODE_MASTER_PAR) ? prom_data : host_data};
  cfl_port cfl_port_inst (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .power_stable_in(power_stable), .cfg_error_in(cfg_error), .io_active_in(io_active),
    .wide_addr_in(wide_addr), .mode_select_pins_in(mode_pins),
    .init_n_in(!(init_oe === 1'b1 || ext_hold)), .init_n_out(init_val), .init_n_oe_out(init_oe),
    .host_pins_in(pins), .config_byte_bus_out(bus_out), .config_byte_bus_oe_out(bus_oe),
    .host_ready_flag_out(ready_flag), .prom_addr_low_out(addr_low), .prom_addr_ext_out(addr_ext),
    .addr_change_strobe_out(strobe), .mode_out(mode), .cfg_byte_out(cfg_byte),
    .cfg_byte_valid_out(valid), .cfg_byte_ready_in(ready_in));
  cfl_prom_model cfl_prom_model_inst (.clk_sys_in(clk_sys_in), .addr_low_in(addr_low),
    .addr_ext_in(addr_ext), .data_out(prom_data));
  // Free running system clock.
  initial begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Full power-up: reset, settle, clear, external hold, then release of the hold line.
  task automatic do_reset(input logic [2:0] m);
    mode_pins = m;
    rstn_in = 0;
    power_stable = 0;
    ext_hold = 1;
    cyc(10);
    check(init_oe === 1'b1 && init_val === 1'b0, "hold line free in reset");
    rstn_in = 1;
    cyc(5);
    check(init_oe === 1'b1, "hold line free before power settles");
    power_stable = 1;
    cyc(30);
    check(init_oe === 1'b1, "hold line free while clearing");
    cyc(80);
    check(init_oe === 1'b0 && mode === MODE_RESET, "hold not kept");
    ext_hold = 0;
    cyc(4);
    check(mode === m, "mode not sampled");
  endtask
  // One strobe cycle; the strobe stays low long enough for the pin synchronisers.
  task automatic host_write(input logic [7:0] b, input logic both, input logic sel);
    for (i = 0; i < 60 && ready_flag !== 1'b1; i++) cyc(1);
    if (sel) exp_q.push_back(b);
    host_data = b;
    write_strobe_n = 0;
    read_strobe_n = ~both;
    cyc(4);
    if (both) check(bus_oe === 1'b0, "read won over write");
    write_strobe_n = 1;
    read_strobe_n = 1;
    cyc(4);
  endtask
  task automatic host_read(input logic [7:0] e);
    read_strobe_n = 0;
    cyc(4);
    check(bus_oe === 1'b1 && bus_out === e, "status read");
    read_strobe_n = 1;
    cyc(3);
    check(bus_oe === 1'b0, "bus still driven");
  endtask
  // Consumer of the buffered byte; random readiness makes it stall now and then.
  always @(negedge clk_sys_in) begin
    ready_in <= cons_rand ? 1'($random(seed)) : cons_en;
  end
  // Takes the oldest note whenever a byte is handed over, and watches the PROM address.
  always @(posedge clk_sys_in) begin
    cycles++;
    if (valid === 1'b1 && ready_in === 1'b1 && rstn_in) begin
      if (exp_q.size() == 0) check(1'b0, "unexpected byte");
      else check(cfg_byte === exp_q.pop_front(), "byte mismatch");
    end
    if (strobe === 1'b1) begin
      strobes++;
      strobe_seen = 1;
    end
    if (rstn_in && addr_low !== last_addr) begin
      check(addr_low === last_addr + 18'h1 && strobe_seen, "address step");
      strobe_seen = 0;
    end
    last_addr = addr_low;
    if (cycles > TIMEOUT_CYC) begin
      miscompares++;
      finish_test();
    end
  end
  // Main sequence: peripheral, express, master serial, then master parallel, each after a reset.
  initial begin
    do_reset(MODE_PERIPH);
    cs_low_n = 0;
    cs_high = 1;
    host_read(8'hff);
    cons_en = 0;
    host_write(8'ha5, 0, 1);
    check(ready_flag === 1'b0, "ready while full");
    host_read(8'h7f);
    cons_en = 1;
    cons_rand = 1;
    repeat (6) host_write(8'($random(seed)), 0, 1);
    host_write(8'h3c, 1, 1);
    cs_high = 0;
    host_write(8'h11, 0, 0);
    cs_high = 1;
    cs_low_n = 1;
    host_write(8'h22, 0, 0);
    cs_low_n = 0;
    cyc(10);
    check(exp_q.size() == 0 && init_oe === 1'b0, "bytes lost");
    cfg_error = 1;
    cyc(2);
    cfg_error = 0;
    cyc(2);
    check(init_oe === 1'b1, "error not flagged");
    // Express mode: the high select alone gates writes, the low select is ignored.
    do_reset(MODE_EXPRESS);
    cs_low_n = 1;
    cs_high = 1;
    host_write(8'h96, 0, 1);
    cs_high = 0;
    host_write(8'h69, 0, 0);
    cyc(10);
    check(exp_q.size() == 0 && bus_oe === 1'b0, "express chain enable");
    // Master serial ignores a data error until its extra hold time has passed.
    do_reset(MODE_MASTER_SER);
    cfg_error = 1;
    cyc(700);
    check(init_oe === 1'b0, "master serial left hold early");
    cyc(60);
    check(init_oe === 1'b1, "master serial error not flagged");
    cfg_error = 0;
    wide_addr = 1;
    for (i = 0; i < 40; i++) exp_q.push_back(8'(i) ^ 8'h5a);
    do_reset(MODE_MASTER_PAR);
    cyc(700);
    check(strobes == 0 && addr_low === 18'h00000, "left hold early");
    for (i = 0; i < 900 && exp_q.size() > 24; i++) cyc(1);
    check(exp_q.size() <= 24 && addr_ext === 4'h0, "PROM fetch");
    cons_rand = 0;
    cons_en = 0;
    io_active = 1;
    cyc(3);
    cfg_error = 1;
    cyc(3);
    check(init_oe === 1'b0, "hold line not released");
    finish_test();
  end
endmodule
